// ==== src/uasjo_alu.sv ====
// Combinational arithmetic unit for the unary and literal operations.
`timescale 1ns/1ps
module uasjo_alu (
  // Operands in, result out
  uasjo_alu_if.alu bus
);
  import uasjo_pkg::*;

  always_comb begin
    unique case (bus.op)
      invert_reg_op: bus.result = ~bus.operand;
      reduce_by_one_op,
      reduce_skip_on_null_op: bus.result = bus.operand - DATA_ONE;
      add_one_op,
      add_one_skip_on_null_op: bus.result = bus.operand + DATA_ONE;
      or_literal_into_accum_op: bus.result = bus.accum | bus.literal;
      no_op,
      jump_absolute_op: bus.result = bus.operand;
    endcase
  end

  assign bus.zero = uasjo_is_null(bus.result);

endmodule

// ==== src/uasjo_alu_if.sv ====
// Interface between the sequencing logic and the arithmetic unit.
`timescale 1ns/1ps
interface uasjo_alu_if;
  import uasjo_pkg::*;
  uasjo_op_t op;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] accum;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] result;
  logic zero;

  modport ctl (output op, output operand, output accum, output literal,
               input result, input zero);
  modport alu (input op, input operand, input accum, input literal,
               output result, output zero);
endinterface

// ==== src/uasjo_core.sv ====
// Execution stage for the unary, skip, jump and OR-literal operations.
// Functional notes
// - Invert addressed file register 0..31, update zero flag.
// - Destination bit 0 sends result to accumulator, 1 to register.
// - Decrement subtracts one, routes by destination, updates zero flag.
// - Increment adds one, routes by destination, updates zero flag.
// - Decrement-skip leaves flags; zero result discards prefetched word.
// - Increment-skip leaves flags; zero result discards prefetched word.
// - Jump loads 9-bit target low, page bits from status 6:5.
// - Jump takes two cycles; prefetched instruction is not executed.
// - OR-literal ORs 8-bit literal into accumulator, updates zero flag.
`timescale 1ns/1ps
module uasjo_core (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Decoded instruction
  input wire logic i_op_valid,
  input wire uasjo_pkg::uasjo_op_t i_op,
  input wire logic [uasjo_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_dest_sel,
  input wire logic [uasjo_pkg::JUMP_W-1:0] i_literal,
  // Current operand values
  input wire logic [uasjo_pkg::DATA_W-1:0] i_reg_data,
  input wire logic [uasjo_pkg::DATA_W-1:0] i_accum,
  input wire logic [uasjo_pkg::STAT_W-1:0] i_status,
  // Write-back
  output logic [uasjo_pkg::DATA_W-1:0] o_result,
  output logic o_accum_we,
  output logic o_reg_we,
  output logic [uasjo_pkg::ADDR_W-1:0] o_reg_addr,
  output logic o_zero_we,
  output logic o_zero_val,
  // Program flow
  output logic o_pc_load,
  output logic [uasjo_pkg::PC_W-1:0] o_pc_target,
  output logic o_flush
);
  import uasjo_pkg::*;

  uasjo_alu_if alu_bus ();

  uasjo_alu u_alu (
    .bus(alu_bus.alu)
  );

  uasjo_state_t state_ff;
  uasjo_state_t nxt_state;
  logic [DATA_W-1:0] result_ff;
  logic accum_we_ff;
  logic reg_we_ff;
  logic [ADDR_W-1:0] reg_addr_ff;
  logic zero_we_ff;
  logic zero_val_ff;
  logic pc_load_ff;
  logic [PC_W-1:0] pc_target_ff;
  logic flush_ff;
  logic op_take;
  logic is_reg_op;
  logic is_skip_op;
  logic flag_op;
  logic skip_now;

  // The word presented during the flush cycle is the discarded prefetch.
  assign op_take = i_op_valid && (state_ff == ST_RUN);

  assign alu_bus.op = i_op;
  assign alu_bus.operand = i_reg_data;
  assign alu_bus.accum = i_accum;
  assign alu_bus.literal = i_literal[DATA_W-1:0];

  assign is_skip_op = (i_op == reduce_skip_on_null_op) ||
                      (i_op == add_one_skip_on_null_op);
  assign is_reg_op = (i_op == invert_reg_op) ||
                     (i_op == reduce_by_one_op) ||
                     (i_op == add_one_op) || is_skip_op;
  assign flag_op = (i_op == invert_reg_op) ||
                   (i_op == reduce_by_one_op) ||
                   (i_op == add_one_op) ||
                   (i_op == or_literal_into_accum_op);
  assign skip_now = op_take && is_skip_op && alu_bus.zero;

  always_comb begin
    nxt_state = ST_RUN;
    if (skip_now || (op_take && i_op == jump_absolute_op)) begin
      nxt_state = ST_FLUSH;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= ST_RUN;
      flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      flush_ff <= (nxt_state == ST_FLUSH);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      result_ff <= DATA_RST;
      accum_we_ff <= 1'b0;
      reg_we_ff <= 1'b0;
      reg_addr_ff <= ADDR_RST;
    end else begin
      result_ff <= alu_bus.result;
      reg_addr_ff <= i_reg_addr;
      accum_we_ff <= op_take && ((is_reg_op && !i_dest_sel) ||
                     (i_op == or_literal_into_accum_op));
      reg_we_ff <= op_take && is_reg_op && i_dest_sel;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      zero_we_ff <= 1'b0;
      zero_val_ff <= 1'b0;
    end else begin
      zero_we_ff <= op_take && flag_op;
      zero_val_ff <= alu_bus.zero;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pc_load_ff <= 1'b0;
      pc_target_ff <= PC_RST;
    end else begin
      pc_load_ff <= op_take && (i_op == jump_absolute_op);
      pc_target_ff <= {i_status[PAGE_MSB:PAGE_LSB], i_literal};
    end
  end

  assign o_result = result_ff;
  assign o_accum_we = accum_we_ff;
  assign o_reg_we = reg_we_ff;
  assign o_reg_addr = reg_addr_ff;
  assign o_zero_we = zero_we_ff;
  assign o_zero_val = zero_val_ff;
  assign o_pc_load = pc_load_ff;
  assign o_pc_target = pc_target_ff;
  assign o_flush = flush_ff;

  property p_invert;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == invert_reg_op) |=>
      (o_result == ~$past(i_reg_data)) && o_zero_we;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inversion result or zero update wrong");

  property p_route;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && is_reg_op) |=>
      (o_reg_we == $past(i_dest_sel)) && (o_accum_we != o_reg_we) &&
      (o_reg_addr == $past(i_reg_addr));
  endproperty
  a_route: assert property (p_route)
    else $error("destination routing wrong");

  property p_reduce;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == reduce_by_one_op) |=>
      (o_result == $past(i_reg_data) - 8'h01) && o_zero_we;
  endproperty
  a_reduce: assert property (p_reduce)
    else $error("decrement result wrong");

  property p_add;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == add_one_op) |=>
      (o_result == $past(i_reg_data) + 8'h01) && o_zero_we;
  endproperty
  a_add: assert property (p_add)
    else $error("increment result wrong");

  property p_reduce_skip;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == reduce_skip_on_null_op) |=>
      !o_zero_we && (o_flush == ($past(i_reg_data) == 8'h01))
      ##1 (!$past(o_flush) || (!o_flush && !o_accum_we && !o_reg_we));
  endproperty
  a_reduce_skip: assert property (p_reduce_skip)
    else $error("decrement-skip flush or flags wrong");

  property p_add_skip;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == add_one_skip_on_null_op) |=>
      !o_zero_we && (o_flush == ($past(i_reg_data) == 8'hFF));
  endproperty
  a_add_skip: assert property (p_add_skip)
    else $error("increment-skip flush or flags wrong");

  property p_jump;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == jump_absolute_op) |=> o_pc_load &&
      (o_pc_target == {$past(i_status[PAGE_MSB:PAGE_LSB]), $past(i_literal)});
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");

  property p_jump_two;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == jump_absolute_op) |=>
      o_flush && !o_zero_we ##1
      !o_flush && !o_pc_load && !o_accum_we && !o_reg_we;
  endproperty
  a_jump_two: assert property (p_jump_two)
    else $error("jump did not discard the prefetched word");

  property p_or_lit;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == or_literal_into_accum_op) |=>
      o_accum_we && !o_reg_we &&
      (o_result == ($past(i_accum) | $past(i_literal[7:0])));
  endproperty
  a_or_lit: assert property (p_or_lit)
    else $error("literal OR wrong");

  property p_zero;
    @(posedge i_clk_sys) disable iff (i_srst)
    o_zero_we |-> (o_zero_val == (o_result == 8'h00));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");

  property p_wrap;
    @(posedge i_clk_sys) disable iff (i_srst)
    (op_take && i_op == reduce_by_one_op && i_reg_data == 8'h00) |=>
      (o_result == 8'hFF) && !o_zero_val;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("decrement did not wrap");

endmodule

// ==== src/uasjo_pkg.sv ====
// Package holding widths, opcodes, states and field positions.
package uasjo_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int JUMP_W = 9;
  localparam int PAGE_W = 2;
  localparam int PC_W = JUMP_W + PAGE_W;
  localparam int STAT_W = 8;
  // Page select bits of the status register feed the top of the target.
  localparam int PAGE_MSB = 6;
  localparam int PAGE_LSB = 5;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;

  typedef enum logic [2:0] {
    no_op = 3'b000,
    invert_reg_op = 3'b001,
    reduce_by_one_op = 3'b010,
    add_one_op = 3'b011,
    reduce_skip_on_null_op = 3'b100,
    add_one_skip_on_null_op = 3'b101,
    jump_absolute_op = 3'b110,
    or_literal_into_accum_op = 3'b111
  } uasjo_op_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_FLUSH = 1'b1
  } uasjo_state_t;

  function automatic logic uasjo_is_null(input logic [DATA_W-1:0] val);
    return val == DATA_ZERO;
  endfunction

endpackage

// ==== verif/testbench.sv ====
// Self-checking bench for the unary, skip, jump and OR-literal stage.
`timescale 1ns/1ps
module testbench;
  import uasjo_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_op_valid = 1'b0;
  uasjo_op_t i_op = no_op;
  logic [ADDR_W-1:0] i_reg_addr = ADDR_RST;
  logic i_dest_sel = 1'b0;
  logic [JUMP_W-1:0] i_literal = 9'h000;
  logic [DATA_W-1:0] i_reg_data = DATA_RST;
  logic [DATA_W-1:0] i_accum = DATA_RST;
  logic [STAT_W-1:0] i_status = 8'h00;
  logic [DATA_W-1:0] o_result;
  logic o_accum_we, o_reg_we, o_zero_we, o_zero_val, o_pc_load, o_flush;
  logic [ADDR_W-1:0] o_reg_addr;
  logic [PC_W-1:0] o_pc_target;
  int err_total = 0;
  int samples_checked = 0;
  logic [15:0] lfsr_q = 16'h0034;
  logic [DATA_W-1:0] e_res = DATA_RST;
  logic e_aw = 1'b0, e_rw = 1'b0, e_zw = 1'b0, e_zv = 1'b0;
  logic e_pl = 1'b0, e_fl = 1'b0;
  logic [ADDR_W-1:0] e_addr = ADDR_RST;
  logic [PC_W-1:0] e_pt = PC_RST;

  uasjo_core uasjo_core_inst (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_reg_addr(i_reg_addr), .i_dest_sel(i_dest_sel),
    .i_literal(i_literal), .i_reg_data(i_reg_data), .i_accum(i_accum),
    .i_status(i_status), .o_result(o_result), .o_accum_we(o_accum_we),
    .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr), .o_zero_we(o_zero_we),
    .o_zero_val(o_zero_val), .o_pc_load(o_pc_load),
    .o_pc_target(o_pc_target), .o_flush(o_flush)
  );

  always #10 i_clk_sys = ~i_clk_sys;

  // Eight shifts per call so that successive values are not correlated.
  function automatic logic [7:0] rnd();
    for (int b = 0; b < 8; b++) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12]
                ^ lfsr_q[10]};
    end
    return lfsr_q[7:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reference model: reads the inputs the design samples at this edge.
  always @(posedge i_clk_sys) begin
    logic [DATA_W-1:0] v;
    logic tk, rop, skp;
    tk = i_op_valid && !e_fl && !i_srst;
    rop = i_op inside {[invert_reg_op:add_one_skip_on_null_op]};
    skp = i_op inside {reduce_skip_on_null_op, add_one_skip_on_null_op};
    case (i_op)
      invert_reg_op: v = ~i_reg_data;
      reduce_by_one_op, reduce_skip_on_null_op: v = i_reg_data - 8'h01;
      add_one_op, add_one_skip_on_null_op: v = i_reg_data + 8'h01;
      or_literal_into_accum_op: v = i_accum | i_literal[7:0];
      default: v = DATA_ZERO;
    endcase
    e_res = v;
    e_addr = i_reg_addr;
    e_aw = tk && ((rop && !i_dest_sel) || i_op == or_literal_into_accum_op);
    e_rw = tk && rop && i_dest_sel;
    e_zw = tk && i_op inside {invert_reg_op, reduce_by_one_op, add_one_op,
                              or_literal_into_accum_op};
    e_zv = (v == DATA_ZERO);
    e_fl = tk && (i_op == jump_absolute_op || (skp && v == DATA_ZERO));
    e_pl = tk && i_op == jump_absolute_op;
    e_pt = {i_status[PAGE_MSB:PAGE_LSB], i_literal};
  end

  always @(negedge i_clk_sys) begin
    check(o_accum_we, e_aw);
    check(o_reg_we, e_rw);
    check(o_zero_we, e_zw);
    check(o_pc_load, e_pl);
    check(o_flush, e_fl);
    if (e_aw || e_rw) check(o_result, e_res);
    if (e_rw) check(o_reg_addr, e_addr);
    if (e_zw) check(o_zero_val, e_zv);
    if (e_pl) check(o_pc_target, e_pt);
  end

  // Operands lean on 00, 01 and ff so that wraps and skips occur often.
  task automatic drive(input int n);
    logic [7:0] r, s;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk_sys);
      r = rnd();
      s = rnd();
      i_op_valid <= r[7:5] != 3'h0;
      i_op <= uasjo_op_t'(r[4:2]);
      i_reg_data <= r[1:0] == 2'h0 ? 8'hff : r[1:0] == 2'h1 ? 8'h01 :
                    r[1:0] == 2'h2 ? 8'h00 : rnd();
      i_dest_sel <= s[0];
      i_reg_addr <= s[5:1];
      i_status <= rnd();
      i_literal <= s[7:6] == 2'h0 ? {s[5], 8'h00} : {s[5], rnd()};
      i_accum <= s[7:6] == 2'h0 ? 8'h00 : rnd();
    end
  endtask

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    drive(1500);
    i_srst <= 1'b1;
    drive(2);
    i_srst <= 1'b0;
    drive(1500);
    @(posedge i_clk_sys);
    i_op_valid <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    complete_run();
  end

  // The tests need about 3020 cycles; allow a generous margin.
  initial begin
    #(20 * 6000);
    err_total++;
    complete_run();
  end
endmodule
